/* verilog/ir_codec_regs.vh */
/*
  timing constants for the pulse-distance infrared codec, derived from the
  50 MHz reference that times the transmit and receive logic.
  assumes the includer works in clock cycles of that reference.
*/
// Operation
// (R1) transmit takes 8-bit address and command
// (R2) transmit timing derived from 50 MHz clock
// (R3) 562.5 us bursts on 38 kHz carrier
// (R4) zero bit: burst plus 562.5 us space
// (R5) one bit: burst plus 1.6875 ms space
// (R6) frame opens with 9 ms burst, 4.5 ms space
// (R7) inverted payload copies follow true data
// (R8) final 562.5 us burst ends the frame
// (R9) frame duration constant for any payload
// (R10) addr, ~addr, cmd, ~cmd, lsb first, 32 bits
// (R11) receive input is active low
// (R12) receiver idles until valid lead code
// (R13) custom code start enters payload read state
// (R14) decoded bits shift into word, word output
// (R15) receive durations measured at 50 MHz
// (R16) receiver outputs address, data, inverted data
// (R17) transmit repeats frames while enable held
// (R18) receiver idles after 32 bits or bad interval
`ifndef IR_CODEC_REGS_VH
`define IR_CODEC_REGS_VH

// reference clock in kHz
`define IR_REF_KHZ 50000
// times in nanoseconds
`define IR_BURST_NS 562500
`define IR_LEAD_MARK_NS 9000000
`define IR_LEAD_SPACE_NS 4500000
`define IR_ONE_SPACE_NS 1687500
`define IR_CARRIER_NS 26316
// cycle counts at the reference rate
`define IR_BURST_CYC ((`IR_BURST_NS * (`IR_REF_KHZ / 1000)) / 1000)
`define IR_LEAD_MARK_CYC ((`IR_LEAD_MARK_NS * (`IR_REF_KHZ / 1000)) / 1000)
`define IR_LEAD_SPACE_CYC ((`IR_LEAD_SPACE_NS * (`IR_REF_KHZ / 1000)) / 1000)
`define IR_ONE_SPACE_CYC ((`IR_ONE_SPACE_NS * (`IR_REF_KHZ / 1000)) / 1000)
`define IR_CARRIER_CYC ((`IR_CARRIER_NS * (`IR_REF_KHZ / 1000)) / 1000)
// payload length in bits
`define IR_PAYLOAD_BITS 32

`endif

/* verilog/ir_tx.v */
/*
  infrared pulse-distance frame transmitter with 38 kHz carrier.
  assumes payload inputs are stable while tx_en is held; clock is the
  reference that the timing counts are scaled for.
*/
`timescale 1ns/1ps
`include "ir_codec_regs.vh"
module ir_tx #(
  parameter BURST_CYC = `IR_BURST_CYC,
  parameter LEAD_MARK_CYC = `IR_LEAD_MARK_CYC,
  parameter LEAD_SPACE_CYC = `IR_LEAD_SPACE_CYC,
  parameter ONE_SPACE_CYC = `IR_ONE_SPACE_CYC,
  parameter CARRIER_CYC = `IR_CARRIER_CYC
) (
  input wire mclk,
  input wire rst_n,
  input wire tx_en,
  input wire [7:0] tx_addr,
  input wire [7:0] tx_cmd,
  output reg led_q,
  output reg tx_busy_q
);
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_LMARK = 5'b00010;
  localparam [4:0] S_LSPACE = 5'b00100;
  localparam [4:0] S_MARK = 5'b01000;
  localparam [4:0] S_SPACE = 5'b10000;

  reg [4:0] state_q;
  reg [19:0] tmr_q;
  reg [5:0] bit_q;
  reg [31:0] shift_q;
  reg [10:0] car_q;
  reg car_on_q;
  wire marking;
  wire last_tick;

  // timer reloads and carrier half period cut to their register widths
  localparam [19:0] LEAD_MARK_T = LEAD_MARK_CYC[19:0];
  localparam [19:0] LEAD_SPACE_T = LEAD_SPACE_CYC[19:0];
  localparam [19:0] BURST_T = BURST_CYC[19:0];
  localparam [19:0] ONE_SPACE_T = ONE_SPACE_CYC[19:0];
  localparam integer CAR_HALF_I = CARRIER_CYC / 2 - 1;
  localparam [10:0] CAR_HALF = CAR_HALF_I[10:0];

  assign marking = (state_q == S_LMARK) || (state_q == S_MARK);
  assign last_tick = (tmr_q == 20'h0_0001);

  // carrier generator, square wave at half period each side
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      car_q <= 11'h000;
      car_on_q <= 1'b0;
    end
    else if (!marking)
    begin
      car_q <= 11'h000;
      car_on_q <= 1'b1;
    end
    else if (car_q == CAR_HALF)
    begin
      car_q <= 11'h000;
      car_on_q <= ~car_on_q; // (R3)
    end
    else
      car_q <= car_q + 11'h001;
  end

  // frame sequencer
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_q <= S_IDLE;
      tmr_q <= 20'h0_0000;
      bit_q <= 6'h00;
      shift_q <= 32'h0000_0000;
      led_q <= 1'b0;
      tx_busy_q <= 1'b0;
    end
    else
    begin
      led_q <= marking & car_on_q; // (R3)
      tx_busy_q <= (state_q != S_IDLE);
      if (state_q != S_IDLE)
        tmr_q <= tmr_q - 20'h0_0001;
      case (state_q)
        S_IDLE:
          if (tx_en) // (R17)
          begin
            // addr, ~addr, cmd, ~cmd sent from bit 0 upward
            shift_q <= {~tx_cmd, tx_cmd, ~tx_addr, tx_addr}; // (R1) (R7) (R10)
            bit_q <= 6'h00;
            tmr_q <= LEAD_MARK_T; // (R6) (R2)
            state_q <= S_LMARK;
          end
        S_LMARK:
          if (last_tick)
          begin
            tmr_q <= LEAD_SPACE_T; // (R6)
            state_q <= S_LSPACE;
          end
        S_LSPACE:
          if (last_tick)
          begin
            tmr_q <= BURST_T;
            state_q <= S_MARK;
          end
        S_MARK:
          if (last_tick)
          begin
            if (bit_q == `IR_PAYLOAD_BITS) // (R8)
              state_q <= S_IDLE; // (R17)
            else
            begin
              tmr_q <= shift_q[0] ? ONE_SPACE_T : BURST_T; // (R4) (R5)
              state_q <= S_SPACE;
            end
          end
        S_SPACE:
          if (last_tick)
          begin
            shift_q <= {1'b0, shift_q[31:1]};
            bit_q <= bit_q + 6'h01;
            tmr_q <= BURST_T; // (R3) (R9)
            state_q <= S_MARK;
          end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end
endmodule // ir_tx

/* verilog/ir_rx.v */
/*
  infrared pulse-distance frame receiver with lead-code detection.
  assumes ir_rx_n is the demodulated, inverted receiver output already
  synchronous to mclk.
*/
`timescale 1ns/1ps
`include "ir_codec_regs.vh"
module ir_rx #(
  parameter BURST_CYC = `IR_BURST_CYC,
  parameter LEAD_MARK_CYC = `IR_LEAD_MARK_CYC,
  parameter LEAD_SPACE_CYC = `IR_LEAD_SPACE_CYC,
  parameter ONE_SPACE_CYC = `IR_ONE_SPACE_CYC
) (
  input wire mclk,
  input wire rst_n,
  input wire ir_rx_n,
  output reg [7:0] rx_addr_q,
  output reg [7:0] rx_data_q,
  output reg [7:0] rx_data_inv_q,
  output reg rx_valid_q,
  output reg rx_error_q
);
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] LEAD_CODE_SEEN_STATE = 3'b010;
  localparam [2:0] PAYLOAD_READ_STATE = 3'b100;

  reg [2:0] state_q;
  reg lvl_q;
  reg [19:0] len_q;
  reg lead_mark_q;
  reg [5:0] cnt_q;
  reg [31:0] word_q;
  wire mark;
  wire edge_seen;

  // nominal intervals cut to the measurement width
  localparam [19:0] BURST_T = BURST_CYC[19:0];
  localparam [19:0] LEAD_MARK_T = LEAD_MARK_CYC[19:0];
  localparam [19:0] LEAD_SPACE_T = LEAD_SPACE_CYC[19:0];
  localparam [19:0] ONE_SPACE_T = ONE_SPACE_CYC[19:0];
  // first space length past the one-bit window; reaching it cuts the frame
  localparam [19:0] SPACE_LIM = ONE_SPACE_T + (ONE_SPACE_T >> 2);

  assign mark = ~ir_rx_n; // (R11)
  assign edge_seen = (mark != lvl_q);

  // interval comparison windows, about a quarter tolerance each
  function in_win;
    input [19:0] len;
    input [19:0] nom;
    begin
      in_win = (len > nom - (nom >> 2)) && (len < nom + (nom >> 2));
    end
  endfunction

  // interval measurement and decode
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_q <= S_IDLE;
      lvl_q <= 1'b0;
      len_q <= 20'h0_0000;
      lead_mark_q <= 1'b0;
      cnt_q <= 6'h00;
      word_q <= 32'h0000_0000;
      rx_addr_q <= 8'h00;
      rx_data_q <= 8'h00;
      rx_data_inv_q <= 8'h00;
      rx_valid_q <= 1'b0;
      rx_error_q <= 1'b0;
    end
    else
    begin
      lvl_q <= mark;
      rx_valid_q <= 1'b0;
      rx_error_q <= 1'b0;
      if (edge_seen)
        len_q <= 20'h0_0001;
      else if (len_q != 20'hF_FFFF)
        len_q <= len_q + 20'h0_0001; // (R15)
      case (state_q)
        S_IDLE:
          // lead detector: long mark then long space
          if (edge_seen && !mark)
            lead_mark_q <= in_win(len_q, LEAD_MARK_T);
          else if (edge_seen && mark)
          begin
            if (lead_mark_q && in_win(len_q, LEAD_SPACE_T))
              state_q <= LEAD_CODE_SEEN_STATE; // (R12)
            lead_mark_q <= 1'b0;
          end
        LEAD_CODE_SEEN_STATE:
          // end of first address burst starts the custom code
          if (edge_seen && !mark)
          begin
            cnt_q <= 6'h00;
            if (in_win(len_q, BURST_T))
              state_q <= PAYLOAD_READ_STATE; // (R13)
            else
            begin
              state_q <= S_IDLE; // (R18)
              rx_error_q <= 1'b1;
            end
          end
        PAYLOAD_READ_STATE:
          if (edge_seen && mark)
          begin
            // space length decides the bit
            if (in_win(len_q, BURST_T) || in_win(len_q, ONE_SPACE_T))
            begin
              word_q <= {in_win(len_q, ONE_SPACE_T), word_q[31:1]}; // (R14)
              cnt_q <= cnt_q + 6'h01;
              if (cnt_q == `IR_PAYLOAD_BITS - 1)
              begin
                state_q <= S_IDLE; // (R18)
                rx_addr_q <= word_q[8:1]; // (R16)
                rx_data_q <= word_q[24:17];
                rx_data_inv_q <= {in_win(len_q, ONE_SPACE_T), word_q[31:25]};
                rx_valid_q <= 1'b1;
              end
            end
            else
            begin
              state_q <= S_IDLE; // (R18)
              rx_error_q <= 1'b1;
            end
          end
          else if (edge_seen && !mark && !in_win(len_q, BURST_T))
          begin
            state_q <= S_IDLE; // (R18)
            rx_error_q <= 1'b1;
          end
          // a space past the longest window ends a cut frame
          else if (!edge_seen && !mark && len_q == SPACE_LIM)
          begin
            state_q <= S_IDLE; // (R18)
            rx_error_q <= 1'b1;
          end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end
endmodule // ir_rx

/* verilog/ir_pulse_distance_codec.v */
/*
  top of the infrared pulse-distance codec: one transmitter, one receiver.
  assumes a 50 MHz mclk, an emitter on ir_led and a demodulating receiver
  on ir_rx_n (low during bursts).
*/
`timescale 1ns/1ps
`include "ir_codec_regs.vh"
module ir_pulse_distance_codec #(
  parameter BURST_CYC = `IR_BURST_CYC,
  parameter LEAD_MARK_CYC = `IR_LEAD_MARK_CYC,
  parameter LEAD_SPACE_CYC = `IR_LEAD_SPACE_CYC,
  parameter ONE_SPACE_CYC = `IR_ONE_SPACE_CYC,
  parameter CARRIER_CYC = `IR_CARRIER_CYC
) (
  input wire mclk,
  input wire rst_n,
  input wire tx_en,
  input wire [7:0] tx_addr,
  input wire [7:0] tx_cmd,
  output wire ir_led,
  output wire tx_busy,
  input wire ir_rx_n,
  output wire [7:0] rx_addr,
  output wire [7:0] rx_data,
  output wire [7:0] rx_data_inv,
  output wire rx_valid,
  output wire rx_error
);
  // transmit path, outputs registered inside
  ir_tx #(
    .BURST_CYC(BURST_CYC),
    .LEAD_MARK_CYC(LEAD_MARK_CYC),
    .LEAD_SPACE_CYC(LEAD_SPACE_CYC),
    .ONE_SPACE_CYC(ONE_SPACE_CYC),
    .CARRIER_CYC(CARRIER_CYC)
  ) u_tx (
    .mclk(mclk),
    .rst_n(rst_n),
    .tx_en(tx_en),
    .tx_addr(tx_addr),
    .tx_cmd(tx_cmd),
    .led_q(ir_led),
    .tx_busy_q(tx_busy)
  );

  // receive path, outputs registered inside
  ir_rx #(
    .BURST_CYC(BURST_CYC),
    .LEAD_MARK_CYC(LEAD_MARK_CYC),
    .LEAD_SPACE_CYC(LEAD_SPACE_CYC),
    .ONE_SPACE_CYC(ONE_SPACE_CYC)
  ) u_rx (
    .mclk(mclk),
    .rst_n(rst_n),
    .ir_rx_n(ir_rx_n),
    .rx_addr_q(rx_addr),
    .rx_data_q(rx_data),
    .rx_data_inv_q(rx_data_inv),
    .rx_valid_q(rx_valid),
    .rx_error_q(rx_error)
  );
endmodule // ir_pulse_distance_codec

/* tb/ir_codec_chk.sv */
/*
  port checker for the codec top, attached by bind.
  assumes the sim-sized lead counts are handed on from the top.
*/
`timescale 1ns/1ps
module ir_codec_chk #(
  parameter int LEAD_MARK_CYC = 320,
  parameter int LEAD_SPACE_CYC = 160
) (
  input wire mclk,
  input wire rst_n,
  input wire ir_led,
  input wire tx_busy,
  input wire [7:0] rx_addr,
  input wire rx_valid,
  input wire rx_error
);
  localparam int LM5 = LEAD_MARK_CYC - 5;
  localparam int LSE = LEAD_MARK_CYC + LEAD_SPACE_CYC - 1;
  logic [15:0] fc_q;
  default clocking @(posedge mclk);
  endclocking
  // cycles since the frame began
  always @(posedge mclk)
    if (!rst_n || !tx_busy) fc_q <= 16'h0000;
    else fc_q <= fc_q + 16'h0001;
  sequence lead_mark_end;
    ir_led ##1 (!ir_led) [*8];
  endsequence
  sequence space_then_burst;
    !ir_led ##1 ir_led;
  endsequence
  a_reset_quiet: assert property (!rst_n |=> !ir_led && !tx_busy && !rx_valid && !rx_error)
    else $error("outputs not cleared by reset");
  a_valid_pulse: assert property (disable iff (!rst_n) rx_valid |=> !rx_valid)
    else $error("frame valid longer than one cycle");
  a_error_pulse: assert property (disable iff (!rst_n) rx_error |=> !rx_error)
    else $error("error flag longer than one cycle");
  a_led_in_frame: assert property (disable iff (!rst_n) ir_led |-> tx_busy)
    else $error("emitter on outside a frame");
  a_lead_start: assert property (disable iff (!rst_n) $rose(tx_busy) |-> ir_led)
    else $error("frame does not open with a burst");
  a_lead_mark: assert property (disable iff (!rst_n) fc_q == LM5 |-> lead_mark_end)
    else $error("lead burst wrong length");
  a_lead_space: assert property (disable iff (!rst_n) fc_q == LSE |-> space_then_burst)
    else $error("lead space wrong length");
  a_addr_hold: assert property (disable iff (!rst_n) $changed(rx_addr) |-> rx_valid || $past(rx_valid))
    else $error("address changed without a frame");
endmodule // ir_codec_chk
bind ir_pulse_distance_codec ir_codec_chk #(.LEAD_MARK_CYC(LEAD_MARK_CYC), .LEAD_SPACE_CYC(LEAD_SPACE_CYC)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .ir_led(ir_led), .tx_busy(tx_busy), .rx_addr(rx_addr),
  .rx_valid(rx_valid), .rx_error(rx_error));

/* tb/ir_link_model.sv */
/*
  emitter-to-receiver link: demodulates the carrier into an active-low line.
  assumes the receiver output has a pull-up, so idle reads high.
*/
`timescale 1ns/1ps
module ir_link_model #(
  parameter int CARRIER_CYC = 8
) (
  input wire mclk,
  input wire led,
  output wire rx_n
);
  int quiet = CARRIER_CYC;
  // cycles since the carrier was last seen
  always @(posedge mclk)
    quiet <= (led === 1'b1) ? 0 : (quiet < CARRIER_CYC ? quiet + 1 : quiet);
  assign rx_n = (quiet >= CARRIER_CYC) && !led;
endmodule // ir_link_model

/* tb/ir_pulse_distance_codec_bench.sv */
/*
  self-checking bench: transmitter looped to receiver through the link model.
  assumes shortened counts; the bench can take over the receive line.
*/
`timescale 1ns/1ps
module ir_pulse_distance_codec_bench;
  localparam int B = 40, LM = 320, LS = 160, OS = 120;
  localparam int FRAME = LM + LS + 49 * B + 16 * OS;
  logic mclk = 0, rst_n = 0, tx_en = 0, inj = 0, inj_v = 1;
  logic [7:0] tx_addr = 0, tx_cmd = 0;
  wire ir_led, tx_busy, rx_valid, rx_error, model_rx_n;
  wire [7:0] rx_addr, rx_data, rx_data_inv;
  wire ir_rx_n = inj ? inj_v : model_rx_n;
  int num_errors = 0, compares = 0, nerr = 0;
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (rx_error === 1'b1) nerr++;
  ir_pulse_distance_codec #(.BURST_CYC(B), .LEAD_MARK_CYC(LM), .LEAD_SPACE_CYC(LS), .ONE_SPACE_CYC(OS),
    .CARRIER_CYC(8)) u_dut (.mclk(mclk), .rst_n(rst_n), .tx_en(tx_en), .tx_addr(tx_addr), .tx_cmd(tx_cmd),
    .ir_led(ir_led), .tx_busy(tx_busy), .ir_rx_n(ir_rx_n), .rx_addr(rx_addr), .rx_data(rx_data),
    .rx_data_inv(rx_data_inv), .rx_valid(rx_valid), .rx_error(rx_error));
  ir_link_model #(.CARRIER_CYC(8)) u_link (.mclk(mclk), .led(ir_led), .rx_n(model_rx_n));
  task final_report;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (exp !== got)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task timeout;
    num_errors++;
    $display("Error wait expected done seen timeout");
    final_report;
  endtask
  // one frame, measuring busy length and valid pulses
  task send_frame(input logic [7:0] a, input logic [7:0] c, output int dur, output int nv);
    int i;
    @(negedge mclk);
    tx_addr = a;
    tx_cmd = c;
    tx_en = 1;
    i = 0;
    while (tx_busy !== 1'b1)
    begin
      @(negedge mclk);
      i++;
      if (i > 10) timeout;
    end
    tx_en = 0;
    dur = 1;
    nv = 0;
    while (tx_busy === 1'b1)
    begin
      @(negedge mclk);
      if (rx_valid === 1'b1) nv++;
      dur++;
      if (dur > 2 * FRAME) timeout;
    end
  endtask
  task frame_expect(input logic [7:0] a, input logic [7:0] c, output int dur);
    logic [7:0] ci;
    int nv;
    ci = ~c;
    send_frame(a, c, dur, nv);
    check("valid count", 1, nv);
    check("rx_addr", a, rx_addr);
    check("rx_data", c, rx_data);
    check("rx_data_inv", ci, rx_data_inv);
    check("frame length", 1, (dur >= FRAME - 2 && dur <= FRAME + 2));
  endtask
  // extreme and mixed payloads; equal lengths
  task t_payload;
    int d0, d1, d2;
    frame_expect(8'h00, 8'h00, d0);
    frame_expect(8'hFF, 8'hA5, d1);
    frame_expect(8'h3C, 8'h81, d2);
    check("frame length equal", d0, d1);
    check("frame length equal", d0, d2);
  endtask
  // enable held: back-to-back frames, stop after release
  task t_repeat;
    int i, n;
    @(negedge mclk);
    tx_addr = 8'h5A;
    tx_cmd = 8'h0F;
    tx_en = 1;
    n = 0;
    for (i = 0; i < 2 * FRAME + 200; i++)
    begin
      @(negedge mclk);
      if (rx_valid === 1'b1) n++;
    end
    tx_en = 0;
    check("repeat valid count", 2, n);
    check("rx_data", 8'h0F, rx_data);
    i = 0;
    while (tx_busy === 1'b1)
    begin
      @(negedge mclk);
      i++;
      if (i > FRAME) timeout;
    end
    repeat (50) @(negedge mclk);
    check("busy after stop", 0, tx_busy);
  endtask
  task drive_rx(input logic v, input int n);
    inj_v = v;
    repeat (n) @(negedge mclk);
  endtask
  // stray pulse while idle, then a good lead code whose first bit space is bad
  task t_bad;
    @(negedge mclk);
    inj = 1;
    nerr = 0;
    drive_rx(0, B);
    drive_rx(1, 2 * LS);
    check("idle error count", 0, nerr);
    drive_rx(0, LM);
    drive_rx(1, LS);
    drive_rx(0, B);
    drive_rx(1, 70);
    drive_rx(0, B);
    drive_rx(1, LS);
    check("bad space error count", 1, nerr);
    // lead code, first burst, then the line stays high: cut frame
    drive_rx(0, LM);
    drive_rx(1, LS);
    drive_rx(0, B);
    drive_rx(1, 2 * OS);
    check("cut frame error count", 2, nerr);
    inj = 0;
  endtask
  initial
  begin
    repeat (2) @(negedge mclk);
    rst_n = 1;
    t_payload;
    t_repeat;
    t_bad;
    final_report;
  end
endmodule // ir_pulse_distance_codec_bench
